// ### adcseq_ctrl.sv
// Converter sequencer control: registers, sequencing, power and pump
`timescale 1ns/1ps
module adcseq_ctrl #(
  parameter int POWERUP_CYCLES = adcseq_pkg::PWRUP_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Serial register port
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             sdo,
  // Converter handshake
  input  wire logic        conv_done,
  output logic             conv_start,
  output logic [2:0]       conv_slot,
  output logic [3:0]       conv_source,
  output logic             conv_src_ground,
  output logic             conv_src_temp,
  output logic [1:0]       diag_rate,
  output logic             adc_power,
  output logic             adc_busy,
  // Charge pump
  output logic             pump_on
);
  import adcseq_pkg::*;

  // Refuse a power-up count the 16-bit counter cannot hold
  if (POWERUP_CYCLES < 1 || POWERUP_CYCLES > 65535) begin : g_bad_powerup
    $error("POWERUP_CYCLES out of range");
  end

  typedef struct packed {
    logic          pump;
    logic [15:0]   ctrl;
    logic [15:0]   dsel;
    adcseq_state_t st;
    logic [15:0]   cnt;
    logic [2:0]    slot;
    logic          pend;
    logic          start;
    logic [3:0]    source;
    logic          src_gnd;
    logic          src_temp;
    logic [1:0]    rate;
    logic          busy;
    logic          power;
  } adcseq_state_reg_t;

  adcseq_state_reg_t s_reg, s_next;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        reg_wr;
  logic [5:0]  mask;
  logic [1:0]  mode;
  logic [3:0]  nxt, first;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Lowest enabled slot at or above a start index: {found, index}
  function automatic logic [3:0] find_slot(input logic [5:0] m, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (m[i] && 4'(i) >= from) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction : find_slot

  // Rate code actually applied to diagnostics
  function automatic logic [1:0] rate_of(input logic [1:0] code);
    logic [1:0] r;
    unique case (code)
      RATE_4K8SPS: r = RATE_4K8SPS;
      RATE_9K6SPS: r = RATE_9K6SPS;
      default:     r = RATE_20SPS;
    endcase
    return r;
  endfunction : rate_of

  // ****************************************************************
  // Register port
  // ****************************************************************
  adcseq_spi u_adcseq_spi (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .sdo       (sdo),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rdata (reg_rdata)
  );

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (reg_addr)
      ADDR_PUMP_CFG:  reg_rdata = {15'h0000, s_reg.pump};
      ADDR_CONV_CTRL: reg_rdata = s_reg.ctrl;
      ADDR_DIAG_SEL:  reg_rdata = s_reg.dsel;
      default:        reg_rdata = 16'h0000;
    endcase
  end

  // Enable mask, channels first then diagnostics
  assign mask  = {s_reg.ctrl[DIAG_EN_MSB:DIAG_EN_LSB], s_reg.ctrl[CHAN_EN_MSB:CHAN_EN_LSB]};
  assign mode  = s_reg.ctrl[SEQ_MSB:SEQ_LSB];
  assign first = find_slot(mask, 4'h0);
  assign nxt   = find_slot(mask, 4'(s_reg.slot) + 4'h1);

  // ****************************************************************
  // Sequencer and register writes
  // ****************************************************************
  always_comb begin
    s_next       = s_reg;
    s_next.start = 1'b0;
    s_next.rate  = rate_of(s_reg.ctrl[RATE_MSB:RATE_LSB]);
    unique case (s_reg.st)
      SQ_IDLE: begin
        if (s_reg.pend) begin
          s_next.pend = 1'b0;
          if (first[3]) begin
            s_next.slot  = first[2:0];
            s_next.start = 1'b1;
            s_next.busy  = 1'b1;
            s_next.st    = SQ_WAIT;
          end
        end else if (mode == SEQ_POWERDN) begin
          s_next.power = 1'b0;
          s_next.st    = SQ_DOWN;
        end
      end
      SQ_WAIT: begin
        if (conv_done) begin
          if (nxt[3]) begin
            s_next.slot  = nxt[2:0];
            s_next.start = 1'b1;
          end else if (mode == SEQ_CONT && first[3]) begin
            s_next.slot  = first[2:0];
            s_next.start = 1'b1;
          end else begin
            s_next.busy = 1'b0;
            s_next.st   = SQ_IDLE;
            if (mode == SEQ_POWERDN) begin
              s_next.power = 1'b0;
              s_next.st    = SQ_DOWN;
            end
          end
        end
      end
      SQ_DOWN: begin
        if (s_reg.pend || mode == SEQ_STANDBY) begin
          s_next.power = 1'b1;
          s_next.cnt   = 16'(POWERUP_CYCLES - 1);
          s_next.st    = SQ_PWRUP;
        end
      end
      SQ_PWRUP: begin
        if (s_reg.cnt == 16'h0000) s_next.st = SQ_IDLE;
        else s_next.cnt = s_reg.cnt - 16'h0001;
      end
    endcase
    if (s_next.start) begin
      s_next.source   = (s_next.slot >= 3'(FIRST_DIAG)) ?
                        s_reg.dsel[4*(s_next.slot - 3'(FIRST_DIAG)) +: SRC_WIDTH] : SRC_AGND;
      s_next.src_gnd  = (s_next.source == SRC_AGND) || (s_next.source == SRC_AGND_ALT);
      s_next.src_temp = (s_next.source == SRC_TEMP);
    end
    // Writes last so a start request beats its own clear
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PUMP_CFG:  s_next.pump = reg_wdata[PUMP_BIT];
        ADDR_CONV_CTRL: begin
          s_next.ctrl = reg_wdata & CTRL_WMASK;
          if (reg_wdata[SEQ_MSB:SEQ_LSB] == SEQ_SINGLE || reg_wdata[SEQ_MSB:SEQ_LSB] == SEQ_CONT)
            s_next.pend = 1'b1;
        end
        ADDR_DIAG_SEL:  s_next.dsel = reg_wdata;
        default:        s_next.pend = s_next.pend;
      endcase
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg       <= '0;
      s_reg.ctrl  <= RESET_VALUE;
      s_reg.dsel  <= RESET_VALUE;
      s_reg.st    <= SQ_IDLE;
      s_reg.power <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign pump_on         = s_reg.pump;
  assign conv_start      = s_reg.start;
  assign conv_slot       = s_reg.slot;
  assign conv_source     = s_reg.source;
  assign conv_src_ground = s_reg.src_gnd;
  assign conv_src_temp   = s_reg.src_temp;
  assign diag_rate       = s_reg.rate;
  assign adc_power       = s_reg.power;
  assign adc_busy        = s_reg.busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_PUMP_FOLLOWS_WRITE: assert property (@(posedge clk) disable iff (reset)
    (ce && reg_wr && reg_addr == ADDR_PUMP_CFG) |=> (pump_on == $past(reg_wdata[PUMP_BIT])))
    else $error("pump does not follow its enable bit");
  AST_RATE_DEFINED: assert property (@(posedge clk) disable iff (reset)
    (ce && s_reg.ctrl[RATE_MSB:RATE_LSB] == RATE_9K6SPS) |=> (diag_rate == RATE_9K6SPS))
    else $error("defined diagnostic rate not applied");
  AST_RATE_FALLBACK: assert property (@(posedge clk) disable iff (reset)
    (ce && s_reg.ctrl[RATE_MSB:RATE_LSB] == 2'h3) |=> (diag_rate == RATE_20SPS))
    else $error("undefined rate not mapped to slowest");
  AST_STANDBY_POWERED: assert property (@(posedge clk) disable iff (reset)
    ($fell(adc_busy) && mode == SEQ_STANDBY) |-> (adc_power && s_reg.st == SQ_IDLE))
    else $error("standby left the converter unpowered");
  AST_SINGLE_ENDS: assert property (@(posedge clk) disable iff (reset)
    (ce && s_reg.st == SQ_WAIT && conv_done && !nxt[3] && mode == SEQ_SINGLE) |=> (!adc_busy && !conv_start))
    else $error("single sequence did not end");
  AST_CONT_REPEATS: assert property (@(posedge clk) disable iff (reset)
    (ce && s_reg.st == SQ_WAIT && conv_done && !nxt[3] && mode == SEQ_CONT) |=> (adc_busy && conv_start))
    else $error("continuous mode did not restart");
  AST_POWERUP_WAIT: assert property (@(posedge clk) disable iff (reset)
    (ce && s_reg.st == SQ_PWRUP && s_reg.cnt != 16'h0000) |=> (!conv_start && s_reg.st == SQ_PWRUP && adc_power))
    else $error("conversion before power-up time");
  AST_ONLY_ENABLED: assert property (@(posedge clk) disable iff (reset)
    (conv_start && $past(ce)) |-> $past(mask[s_next.slot]))
    else $error("disabled slot converted");
  AST_SLOT3_SOURCE: assert property (@(posedge clk) disable iff (reset)
    (conv_start && conv_slot == 3'h5) |-> (conv_source == $past(s_reg.dsel[15:12])))
    else $error("slot 3 source mismatch");
  AST_BUSY_SPAN: assert property (@(posedge clk) disable iff (reset)
    conv_start |-> (adc_busy && adc_power))
    else $error("conversion started while not busy");

endmodule : adcseq_ctrl

// ### adcseq_pkg.sv
// Shared constants and types for the converter sequencer control block
package adcseq_pkg;

  // ****************************************************************
  // Register offsets and layouts
  // ****************************************************************
  localparam logic [6:0]  ADDR_PUMP_CFG  = 7'h3A;
  localparam logic [6:0]  ADDR_CONV_CTRL = 7'h3B;
  localparam logic [6:0]  ADDR_DIAG_SEL  = 7'h3C;
  localparam logic [15:0] RESET_VALUE    = 16'h0000;
  localparam logic [15:0] CTRL_WMASK     = 16'hFF03;  // Bits [7:2] reserved
  localparam logic [15:0] PUMP_WMASK     = 16'h0001;  // Bits [15:1] reserved
  localparam int          PUMP_BIT       = 0;
  localparam int          RATE_MSB       = 15;
  localparam int          RATE_LSB       = 14;
  localparam int          SEQ_MSB        = 13;
  localparam int          SEQ_LSB        = 12;
  localparam int          DIAG_EN_MSB    = 11;
  localparam int          DIAG_EN_LSB    = 8;
  localparam int          CHAN_EN_MSB    = 1;
  localparam int          CHAN_EN_LSB    = 0;
  localparam int          SRC_WIDTH      = 4;
  localparam int          NUM_SLOTS      = 6;        // Channel 1, 2, diag 0..3
  localparam int          FIRST_DIAG     = 2;

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  localparam logic [1:0] SEQ_STANDBY  = 2'h0;
  localparam logic [1:0] SEQ_SINGLE   = 2'h1;
  localparam logic [1:0] SEQ_CONT     = 2'h2;
  localparam logic [1:0] SEQ_POWERDN  = 2'h3;
  localparam logic [1:0] RATE_20SPS   = 2'h0;
  localparam logic [1:0] RATE_4K8SPS  = 2'h1;
  localparam logic [1:0] RATE_9K6SPS  = 2'h2;
  localparam logic [3:0] SRC_AGND     = 4'h0;
  localparam logic [3:0] SRC_TEMP     = 4'h1;
  localparam logic [3:0] SRC_AGND_ALT = 4'hE;

  // ****************************************************************
  // Serial frame and timing
  // ****************************************************************
  localparam int          ADDR_BITS     = 8;
  localparam int          FRAME_BITS    = 24;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          PWRUP_TIME_NS = 100000;
  localparam int          PWRUP_CYCLES  = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {SQ_IDLE, SQ_WAIT, SQ_DOWN, SQ_PWRUP} adcseq_state_t;

endpackage : adcseq_pkg

// ### adcseq_spi.sv
// Serial register port: 24-bit frames, mode 0, MSB first
`timescale 1ns/1ps
module adcseq_spi (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             sdo,
  // Register side
  output logic [6:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  input  wire logic [15:0] reg_rdata
);
  import adcseq_pkg::*;

  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [2:0]  mosi_s;
    logic        sclk_f;
    logic        cs_f;
    logic        mosi_f;
    logic [4:0]  count;
    logic [23:0] shift;
    logic [15:0] tx;
    logic        sdo;
    logic        wr;
  } adcseq_spi_state_t;

  adcseq_spi_state_t s_reg, s_next;
  logic rise, fall;

  // ****************************************************************
  // Synchronise pins, decode edges, shift the frame
  // ****************************************************************
  always_comb begin
    s_next        = s_reg;
    s_next.wr     = 1'b0;
    s_next.sclk_s = {s_reg.sclk_s[1:0], sclk};
    s_next.cs_s   = {s_reg.cs_s[1:0], cs_n};
    s_next.mosi_s = {s_reg.mosi_s[1:0], mosi};
    // A change counts once stages two and three agree
    if (s_reg.sclk_s[1] == s_reg.sclk_s[2]) s_next.sclk_f = s_reg.sclk_s[2];
    if (s_reg.cs_s[1] == s_reg.cs_s[2]) s_next.cs_f = s_reg.cs_s[2];
    if (s_reg.mosi_s[1] == s_reg.mosi_s[2]) s_next.mosi_f = s_reg.mosi_s[2];
    rise = s_next.sclk_f & ~s_reg.sclk_f;
    fall = ~s_next.sclk_f & s_reg.sclk_f;
    if (s_reg.cs_f) begin
      s_next.count = 5'h00;
    end else if (rise) begin
      s_next.shift = {s_reg.shift[22:0], s_reg.mosi_f};
      s_next.count = s_reg.count + 5'h01;
      if (s_reg.count == 5'(FRAME_BITS - 1)) begin
        s_next.wr = ~s_reg.shift[22];    // Flag bit low means write
      end
    end else if (fall && s_reg.count == 5'(ADDR_BITS)) begin
      // Whole address is in, so the read mux now shows the addressed word
      s_next.sdo = reg_rdata[15];
      s_next.tx  = {reg_rdata[14:0], 1'b0};
    end else if (fall && s_reg.count > 5'(ADDR_BITS)) begin
      s_next.sdo = s_reg.tx[15];
      s_next.tx  = {s_reg.tx[14:0], 1'b0};
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg        <= '0;
      s_reg.sclk_f <= 1'b0;
      s_reg.cs_f   <= 1'b1;
      s_reg.cs_s   <= 3'h7;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign sdo       = s_reg.sdo;
  assign reg_wr    = s_reg.wr;
  assign reg_wdata = s_reg.shift[15:0];
  // Address lives in the low bits of the first byte until shifted out
  assign reg_addr  = (s_reg.count > 5'(ADDR_BITS)) ? s_reg.shift[22:16] : s_reg.shift[6:0];

endmodule : adcseq_spi

// ### adcseq_ctrl_test.sv
// Self-checking testbench for the converter sequencer control block
`timescale 1ns/1ps
module adcseq_ctrl_test;
  import adcseq_pkg::*;

  // ****************************************************************
  // Signals and design instance
  // ****************************************************************
  localparam int HALF = 8;  // Serial clock half period in clk cycles
  localparam int PWRUP = 16;  // Shortened power-up interval
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] dsel;
    logic [1:0]  rate;
  } adcseq_row_t;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        sclk = 1'b0;
  logic        cs_n = 1'b1;
  logic        mosi = 1'b0;
  logic        sdo;
  logic        conv_done = 1'b0;
  logic        conv_start;
  logic [2:0]  conv_slot;
  logic [3:0]  conv_source;
  logic        conv_src_ground;
  logic        conv_src_temp;
  logic [1:0]  diag_rate;
  logic        adc_power;
  logic        adc_busy;
  logic        pump_on;
  logic [15:0] rd;
  int          bad_count = 0;
  int          checks = 0;
  int          n;
  adcseq_row_t rows [6] = '{
    '{16'h1001, 16'h0000, 2'h0}, '{16'h5002, 16'h1000, 2'h1}, '{16'h9F03, 16'hE000, 2'h2},
    '{16'hD500, 16'h0000, 2'h0}, '{16'h1A00, 16'h1000, 2'h0}, '{16'h1800, 16'h7000, 2'h0}};

  adcseq_ctrl #(.POWERUP_CYCLES(PWRUP)) u_adcseq_ctrl (
    .clk(clk), .reset(reset), .ce(ce), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .sdo(sdo),
    .conv_done(conv_done), .conv_start(conv_start), .conv_slot(conv_slot),
    .conv_source(conv_source), .conv_src_ground(conv_src_ground), .conv_src_temp(conv_src_temp),
    .diag_rate(diag_rate), .adc_power(adc_power), .adc_busy(adc_busy), .pump_on(pump_on));

  // Clock generation
  always #5 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // One 24-bit serial frame, mode 0, MSB first
  task automatic spi(input logic rdf, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] f;
    f = {rdf, a, d};
    q = 16'h0000;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk) mosi <= f[23-i];
      repeat (HALF) @(posedge clk);
      if (i >= 8) q[23-i] = sdo;
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask : spi

  // Wait for a launch and check slot, busy and, for slot 5 and the channel slots, source
  task automatic expect_start(input int s, input logic [3:0] src);
    // A start pulse may launch on the very edge the caller returned on
    #1;
    for (n = 0; n < 3000 && conv_start !== 1'b1; n++) @(posedge clk) #1;
    if (n >= 3000) begin
      chk(16'h0, 16'h1, "launch timeout");
      report_and_stop();
    end
    chk(16'(conv_slot), 16'(s), "slot order");
    chk(16'(adc_busy), 16'h1, "busy in sequence");
    if (s == 5) begin
      chk(16'(conv_source), 16'(src), "slot3 source");
      chk(16'(conv_src_ground), 16'(src == 4'h0 || src == 4'hE), "ground");
      chk(16'(conv_src_temp), 16'(src == 4'h1), "temp");
    end
    if (s < 2) chk(16'(conv_source), 16'h0, "channel source");
  endtask : expect_start

  // Converter finishes after a short delay
  task automatic give_done();
    repeat (3) @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk) conv_done <= 1'b0;
  endtask : give_done

  // Serve one whole sequence of enabled slots
  task automatic run_seq(input logic [5:0] mask, input logic [3:0] src);
    for (int s = 0; s < 6; s++) begin
      if (mask[s]) begin
        expect_start(s, src);
        give_done();
      end
    end
    repeat (2) @(posedge clk) #1;
    chk(16'(adc_busy), 16'h0, "busy after sequence");
  endtask : run_seq

  // No launch may appear in an idle window
  task automatic no_start(input int cyc);
    for (int i = 0; i < cyc; i++) @(posedge clk) #1 chk(16'(conv_start), 16'h0, "idle launch");
  endtask : no_start

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk) #1;
    chk(16'(pump_on), 16'h0, "pump after reset");
    chk(16'(adc_power), 16'h1, "standby powered");
    spi(1'b1, ADDR_CONV_CTRL, 16'h0000, rd);
    chk(rd, RESET_VALUE, "ctrl reset");
    $display("test reset values done");

    // Table of single sequences
    foreach (rows[r]) begin
      chk(16'(adc_busy), 16'h0, "busy before start");
      spi(1'b0, ADDR_DIAG_SEL, rows[r].dsel, rd);
      fork
        spi(1'b0, ADDR_CONV_CTRL, rows[r].ctrl, rd);
        run_seq({rows[r].ctrl[11:8], rows[r].ctrl[1:0]}, rows[r].dsel[15:12]);
      join
      chk(16'(diag_rate), 16'(rows[r].rate), "diag rate");
      no_start(30);
    end
    $display("test single sequences done");

    // Reserved bits, unmapped place, pump enable
    spi(1'b0, ADDR_CONV_CTRL, 16'h8FFF, rd);
    spi(1'b1, ADDR_CONV_CTRL, 16'h0000, rd);
    chk(rd, 16'h8F03, "ctrl readback");
    spi(1'b0, 7'h3D, 16'hFFFF, rd);
    spi(1'b1, 7'h3D, 16'h0000, rd);
    chk(rd, 16'h0000, "unmapped read");
    spi(1'b0, ADDR_PUMP_CFG, 16'hFFFF, rd);
    spi(1'b1, ADDR_PUMP_CFG, 16'h0000, rd);
    chk(rd, 16'h0001, "pump readback");
    chk(16'(pump_on), 16'h1, "pump on");
    spi(1'b0, ADDR_PUMP_CFG, 16'hFFFE, rd);
    chk(16'(pump_on), 16'h0, "pump off");
    $display("test registers done");

    // Continuous run, then standby stop in mid-sequence
    fork
      spi(1'b0, ADDR_CONV_CTRL, 16'h2003, rd);
      begin
        repeat (2) begin
          expect_start(0, 4'h0);
          give_done();
          expect_start(1, 4'h0);
          give_done();
        end
        expect_start(0, 4'h0);
      end
    join
    spi(1'b0, ADDR_CONV_CTRL, 16'h0003, rd);
    give_done();
    expect_start(1, 4'h0);
    give_done();
    repeat (2) @(posedge clk) #1;
    chk(16'(adc_busy), 16'h0, "busy after stop");
    chk(16'(adc_power), 16'h1, "powered after standby");
    no_start(60);
    $display("test continuous done");

    // Power down, then restart waits the power-up time
    chk(16'(adc_busy), 16'h0, "idle before control change");
    spi(1'b0, ADDR_CONV_CTRL, 16'h3000, rd);
    repeat (4) @(posedge clk) #1;
    chk(16'(adc_power), 16'h0, "powered down");
    fork
      spi(1'b0, ADDR_CONV_CTRL, 16'h1001, rd);
      begin
        for (n = 0; n < 1000 && adc_power !== 1'b1; n++) @(posedge clk) #1;
        chk(16'(n < 1000), 16'h1, "power-up start");
        if (n >= 1000) report_and_stop();
        for (n = 0; n < 1000 && conv_start !== 1'b1; n++) @(posedge clk) #1;
        chk(16'(n >= PWRUP && n < 1000), 16'h1, "power-up wait");
        if (n >= 1000) report_and_stop();
        chk(16'(conv_slot), 16'h0, "slot after power-up");
        give_done();
      end
    join
    // Standby code also brings a powered-down converter back
    spi(1'b0, ADDR_CONV_CTRL, 16'h3000, rd);
    chk(16'(adc_power), 16'h0, "down again");
    spi(1'b0, ADDR_CONV_CTRL, 16'h0000, rd);
    chk(16'(adc_power), 16'h1, "standby powers up");
    $display("test power down done");

    // Second reset in mid-run
    spi(1'b0, ADDR_PUMP_CFG, 16'h0001, rd);
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk) #1;
    chk(16'(pump_on), 16'h0, "pump after second reset");
    spi(1'b1, ADDR_DIAG_SEL, 16'h0000, rd);
    chk(rd, RESET_VALUE, "select reset");
    $display("test second reset done");
    report_and_stop();
  end

endmodule : adcseq_ctrl_test
